//--- rgd_consts.svh
// Register offsets, field positions, reset values and tuning counts of the DLL skew block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses and word-aligned registers.
`ifndef RGD_CONSTS_SVH
`define RGD_CONSTS_SVH

`define RGD_ADDR_W 8
`define RGD_OFS_MODE 8'h00
`define RGD_OFS_RXCTL 8'h04
`define RGD_OFS_TXCTL 8'h08
`define RGD_OFS_DLLRST 8'h0C
`define RGD_OFS_STAT 8'h10

// Mode register fields.
`define RGD_MODE_DEST 0
`define RGD_MODE_SPD_LO 1
`define RGD_MODE_SPD_HI 2

// DLL control register fields, same layout for both directions.
`define RGD_CTL_BYP 0
`define RGD_CTL_TDIS 1
`define RGD_CTL_ADJ_LO 4
`define RGD_CTL_ADJ_HI 7
`define RGD_CTL_SEL_LO 8
`define RGD_CTL_SEL_HI 13

// DLL reset register fields.
`define RGD_RST_RX 0
`define RGD_RST_TX 1

// Status register fields.
`define RGD_ST_RXTAP_LO 0
`define RGD_ST_RXTAP_HI 5
`define RGD_ST_TXTAP_LO 8
`define RGD_ST_TXTAP_HI 13
`define RGD_ST_RXTUNED 16
`define RGD_ST_TXTUNED 17
`define RGD_ST_RXACT 18
`define RGD_ST_TXACT 19

// Reset values.
`define RGD_MODE_RST 32'h0000_0004
`define RGD_RXCTL_RST 32'h0000_1000
`define RGD_TXCTL_RST 32'h0000_1001
`define RGD_DLLRST_RST 32'h0000_0000

// Speed codes: 10, 100 and 1000 Mbps.
`define RGD_SPD_10 2'h0
`define RGD_SPD_100 2'h1
`define RGD_SPD_1000 2'h2

// Fixed delay of the chain and the nominal delay of one tap, in picoseconds.
`define RGD_DLY_PS 2000
`define RGD_TAP_PS 62
// Link clock cycles between two tuning updates.
`define RGD_TUNE_CYC 16

`define RGD_RESP_OKAY 2'h0
`define RGD_RESP_SLVERR 2'h2

`endif

//--- rgd_pkg.sv
// Types shared by the DLL skew block: configuration and status words of one DLL.
// Assumes rgd_consts.svh is included by the design file that uses these types.
package rgd_pkg;

	typedef struct packed {
		logic rst;
		logic bypass;
		logic tune_dis;
		logic [3:0] adj;
		logic [5:0] sel;
	} rgd_dll_cfg_t;

	// Everything the link domain needs, carried across as one word.
	typedef struct packed {
		logic [1:0] spd;
		logic dest;
		rgd_dll_cfg_t tx;
		rgd_dll_cfg_t rx;
	} rgd_link_cfg_t;

	typedef struct packed {
		logic active;
		logic tuned;
		logic [5:0] tap;
	} rgd_dll_stat_t;

	typedef enum logic [3:0] {
		TS_RESET = 4'b0001,
		TS_INIT = 4'b0010,
		TS_TUNED = 4'b0100,
		TS_FIXED = 4'b1000
	} rgd_tune_st_t;

endpackage

//--- rgd_dll_skew.sv
// DLL clock skew control: AXI4-Lite registers on mclk_i, tap engines on the link clock.
// Assumes the analog delay chain takes a tap select and a bypass select from this block.
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "rgd_consts.svh"

// One tap engine; runs wholly in the link clock domain.
module rgd_dll_tuner
	import rgd_pkg::*;
#(
	parameter int TUNE_CYC = `RGD_TUNE_CYC,
	parameter logic [5:0] NOM_TAPS = 6'(`RGD_DLY_PS / `RGD_TAP_PS)
) (
	input wire logic lclk_i,
	input wire logic lrst_i,
	input wire rgd_dll_cfg_t cfg_i,
	input wire logic active_i,
	output rgd_dll_stat_t stat_o
);
	rgd_tune_st_t st_ff;
	rgd_tune_st_t nxt_st;
	logic [5:0] tap_ff;
	logic [5:0] nxt_tap;
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic tick;
	logic [5:0] tuned_tap;

	// Larger adjust gives a shorter delay; saturate at zero taps.
	function automatic logic [5:0] adj_tap(input logic [5:0] nom, input logic [3:0] adj);
		adj_tap = (nom > {2'h0, adj}) ? 6'(nom - {2'h0, adj}) : 6'h00;
	endfunction

	assign tick = (cnt_ff == 8'(TUNE_CYC - 1));
	assign tuned_tap = adj_tap(NOM_TAPS, cfg_i.adj);
	assign nxt_cnt = (st_ff == TS_RESET || tick) ? 8'h00 : 8'(cnt_ff + 8'h01);

	// Tuning sequence: reset, initial tap, then periodic updates or a fixed tap.
	always_comb begin
		nxt_st = st_ff;
		nxt_tap = tap_ff;
		unique case (st_ff)
			TS_RESET: begin
				nxt_tap = 6'h00;
				if (!cfg_i.rst) begin
					nxt_st = cfg_i.tune_dis ? TS_FIXED : TS_INIT;
					nxt_tap = cfg_i.sel;
				end
			end
			TS_INIT: begin
				if (cfg_i.tune_dis) begin
					nxt_st = TS_FIXED;
				end else if (tick) begin
					nxt_st = TS_TUNED;
					nxt_tap = tuned_tap;
				end
			end
			TS_TUNED: begin
				if (cfg_i.tune_dis) begin
					nxt_st = TS_FIXED;
				end else if (tick) begin
					nxt_tap = tuned_tap;
				end
			end
			TS_FIXED: begin
				nxt_tap = cfg_i.sel;
				if (!cfg_i.tune_dis) begin
					nxt_st = TS_INIT;
				end
			end
		endcase
		if (cfg_i.rst) begin
			nxt_st = TS_RESET;
			nxt_tap = 6'h00;
		end
	end

	// State and tap registers; the tap reaches the chain through the output flops in rgd_dll_skew.
	always_ff @(posedge lclk_i or posedge lrst_i) begin
		if (lrst_i) begin
			st_ff <= TS_RESET;
			tap_ff <= 6'h00;
			cnt_ff <= 8'h00;
			stat_o <= '0;
		end else begin
			st_ff <= nxt_st;
			tap_ff <= nxt_tap;
			cnt_ff <= nxt_cnt;
			stat_o <= '{active: active_i, tuned: (nxt_st == TS_TUNED), tap: nxt_tap};
		end
	end
endmodule

module rgd_dll_skew
	import rgd_pkg::*;
#(
	parameter int TUNE_CYC = `RGD_TUNE_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic lclk_i,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [`RGD_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [`RGD_ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic rx_dly_en_o,
	output logic tx_dly_en_o,
	output logic [5:0] rx_tap_o,
	output logic [5:0] tx_tap_o,
	output logic both_edges_data_o
);
	// Software registers, bus state and crossing handshake in the mclk_i domain.
	logic [31:0] mode_ff;
	logic [31:0] rxctl_ff;
	logic [31:0] txctl_ff;
	logic [31:0] dllrst_ff;
	logic [31:0] stat_ff;
	logic [31:0] nxt_mode;
	logic [31:0] nxt_rxctl;
	logic [31:0] nxt_txctl;
	logic [31:0] nxt_dllrst;
	logic aw_got_ff;
	logic w_got_ff;
	logic [`RGD_ADDR_W-1:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic req_ff;
	rgd_link_cfg_t hold_ff;
	logic ack_s1_ff;
	logic ack_s2_ff;
	logic ack_s3_ff;
	// Link domain: reset synchroniser, request synchroniser, loaded config, status hold.
	logic lrst_s1_ff;
	logic lrst_ff;
	logic req_s1_ff;
	logic req_s2_ff;
	logic req_s3_ff;
	logic ack_ff;
	rgd_link_cfg_t lcfg_ff;
	logic [31:0] lstat_ff;
	rgd_dll_stat_t rx_stat;
	rgd_dll_stat_t tx_stat;

	// Fold byte enables into a register's old value.
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			old[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
		end
		wmerge = old;
	endfunction

	function automatic logic mapped(input logic [`RGD_ADDR_W-1:0] a);
		mapped = (a == `RGD_OFS_MODE) || (a == `RGD_OFS_RXCTL) || (a == `RGD_OFS_TXCTL) ||
			(a == `RGD_OFS_DLLRST) || (a == `RGD_OFS_STAT);
	endfunction

	// Each direction keeps its own select and adjust, so the two chains never share a field.
	function automatic rgd_dll_cfg_t dll_pack(input logic [31:0] ctl, input logic rst);
		dll_pack = '{rst: rst, bypass: ctl[`RGD_CTL_BYP], tune_dis: ctl[`RGD_CTL_TDIS],
			adj: ctl[`RGD_CTL_ADJ_HI:`RGD_CTL_ADJ_LO],
			sel: ctl[`RGD_CTL_SEL_HI:`RGD_CTL_SEL_LO]};
	endfunction
	function automatic rgd_link_cfg_t cfg_pack(input logic [31:0] md, input logic [31:0] rx,
			input logic [31:0] tx, input logic [31:0] rs);
		cfg_pack = '{spd: md[`RGD_MODE_SPD_HI:`RGD_MODE_SPD_LO], dest: md[`RGD_MODE_DEST],
			tx: dll_pack(tx, rs[`RGD_RST_TX]), rx: dll_pack(rx, rs[`RGD_RST_RX])};
	endfunction
	localparam rgd_link_cfg_t LCFG_RST = cfg_pack(`RGD_MODE_RST, `RGD_RXCTL_RST,
		`RGD_TXCTL_RST, `RGD_DLLRST_RST);

	// Write decode: a write commits once both address and data are in hand.
	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire aw_have = aw_got_ff | aw_hs;
	wire w_have = w_got_ff | w_hs;
	wire [`RGD_ADDR_W-1:0] wa = aw_got_ff ? awaddr_ff : s_axi_awaddr;
	wire [31:0] wd = w_got_ff ? wdata_ff : s_axi_wdata;
	wire [3:0] wb = w_got_ff ? wstrb_ff : s_axi_wstrb;
	wire wr_go = aw_have & w_have & ~s_axi_bvalid;
	wire rd_hs = s_axi_arvalid & s_axi_arready;

	// Only bits with a meaning are writable; the rest read as zero.
	assign nxt_mode = (wr_go && wa == `RGD_OFS_MODE) ?
		wmerge(mode_ff, wd, wb) & 32'h0000_0007 : mode_ff;
	assign nxt_rxctl = (wr_go && wa == `RGD_OFS_RXCTL) ?
		wmerge(rxctl_ff, wd, wb) & 32'h0000_3FF3 : rxctl_ff;
	assign nxt_txctl = (wr_go && wa == `RGD_OFS_TXCTL) ?
		wmerge(txctl_ff, wd, wb) & 32'h0000_3FF3 : txctl_ff;
	// Reset bits stay as written; hardware never clears them.
	assign nxt_dllrst = (wr_go && wa == `RGD_OFS_DLLRST) ?
		wmerge(dllrst_ff, wd, wb) & 32'h0000_0003 : dllrst_ff;

	// Read decode.
	wire [31:0] rd_mux =
		(s_axi_araddr == `RGD_OFS_MODE) ? mode_ff :
		(s_axi_araddr == `RGD_OFS_RXCTL) ? rxctl_ff :
		(s_axi_araddr == `RGD_OFS_TXCTL) ? txctl_ff :
		(s_axi_araddr == `RGD_OFS_DLLRST) ? dllrst_ff :
		(s_axi_araddr == `RGD_OFS_STAT) ? stat_ff : 32'h0000_0000;

	// Configuration word handed to the link domain, both directions side by side.
	wire rgd_link_cfg_t cfg_word = cfg_pack(mode_ff, rxctl_ff, txctl_ff, dllrst_ff);
	wire ack_edge = ack_s2_ff ^ ack_s3_ff;
	wire hs_idle = (req_ff == ack_s2_ff);

	// Bus registers and the request side of the crossing.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_ff <= `RGD_MODE_RST;
			rxctl_ff <= `RGD_RXCTL_RST;
			txctl_ff <= `RGD_TXCTL_RST;
			dllrst_ff <= `RGD_DLLRST_RST;
			stat_ff <= 32'h0000_0000;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RGD_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RGD_RESP_OKAY;
			req_ff <= 1'b0;
			hold_ff <= '0;
			ack_s1_ff <= 1'b0;
			ack_s2_ff <= 1'b0;
			ack_s3_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			rxctl_ff <= nxt_rxctl;
			txctl_ff <= nxt_txctl;
			dllrst_ff <= nxt_dllrst;
			aw_got_ff <= aw_have & ~wr_go;
			w_got_ff <= w_have & ~wr_go;
			if (aw_hs) begin
				awaddr_ff <= s_axi_awaddr;
			end
			if (w_hs) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			s_axi_awready <= ~aw_have & ~(s_axi_bvalid & ~s_axi_bready);
			s_axi_wready <= ~w_have & ~(s_axi_bvalid & ~s_axi_bready);
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(wa) ? `RGD_RESP_OKAY : `RGD_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
			if (rd_hs) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= mapped(s_axi_araddr) ? `RGD_RESP_OKAY : `RGD_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			ack_s1_ff <= ack_ff;
			ack_s2_ff <= ack_s1_ff;
			ack_s3_ff <= ack_s2_ff;
			// Status word is stable in the link hold while the acknowledge travels back.
			if (ack_edge) begin
				stat_ff <= lstat_ff;
			end
			if (hs_idle && !ack_edge) begin
				hold_ff <= cfg_word;
				req_ff <= ~req_ff;
			end
		end
	end

	// Link domain reset: asserts at once, releases on the link clock.
	always_ff @(posedge lclk_i or posedge rst_i) begin
		if (rst_i) begin
			lrst_s1_ff <= 1'b1;
			lrst_ff <= 1'b1;
		end else begin
			lrst_s1_ff <= 1'b0;
			lrst_ff <= lrst_s1_ff;
		end
	end

	// Link side of the handshake: load config and snapshot status on each request edge.
	always_ff @(posedge lclk_i or posedge lrst_ff) begin
		if (lrst_ff) begin
			req_s1_ff <= 1'b0;
			req_s2_ff <= 1'b0;
			req_s3_ff <= 1'b0;
			ack_ff <= 1'b0;
			lcfg_ff <= LCFG_RST;
			lstat_ff <= 32'h0000_0000;
		end else begin
			req_s1_ff <= req_ff;
			req_s2_ff <= req_s1_ff;
			req_s3_ff <= req_s2_ff;
			if (req_s2_ff ^ req_s3_ff) begin
				lcfg_ff <= hold_ff;
				lstat_ff <= {12'h000, tx_stat.active, rx_stat.active, tx_stat.tuned,
					rx_stat.tuned, 2'h0, tx_stat.tap, 2'h0, rx_stat.tap};
				ack_ff <= ~ack_ff;
			end
		end
	end

	// Mode dest set puts the 2 ns delay on the transmit chain alone; with dest clear each bypass removes its own chain's delay.
	wire rx_act = ~lcfg_ff.dest & ~lcfg_ff.rx.bypass;
	wire tx_act = lcfg_ff.dest | ~lcfg_ff.tx.bypass;

	rgd_dll_tuner #(.TUNE_CYC(TUNE_CYC)) u_rx (
		.lclk_i(lclk_i),
		.lrst_i(lrst_ff),
		.cfg_i(lcfg_ff.rx),
		.active_i(rx_act),
		.stat_o(rx_stat)
	);

	rgd_dll_tuner #(.TUNE_CYC(TUNE_CYC)) u_tx (
		.lclk_i(lclk_i),
		.lrst_i(lrst_ff),
		.cfg_i(lcfg_ff.tx),
		.active_i(tx_act),
		.stat_o(tx_stat)
	);

	// Chain controls leave from flops; a cleared enable selects the bypass multiplexer.
	always_ff @(posedge lclk_i or posedge lrst_ff) begin
		if (lrst_ff) begin
			rx_dly_en_o <= 1'b0;
			tx_dly_en_o <= 1'b0;
			rx_tap_o <= 6'h00;
			tx_tap_o <= 6'h00;
			both_edges_data_o <= 1'b0;
		end else begin
			rx_dly_en_o <= rx_stat.active;
			tx_dly_en_o <= tx_stat.active;
			rx_tap_o <= rx_stat.tap;
			tx_tap_o <= tx_stat.tap;
			// Data on both edges only at gigabit; control always uses both edges.
			both_edges_data_o <= (lcfg_ff.spd == `RGD_SPD_1000);
		end
	end
endmodule
`default_nettype wire

//--- rgd_dll_skew_asserts.sv
// Concurrent checks on the ports of the DLL skew block: bus handshakes and link outputs.
// Assumes the bench leaves the registers untouched for 60 link cycles after each reset.
`timescale 1ns/100ps
`default_nettype none
module rgd_dll_skew_asserts #(
	parameter int TUNE_CYC = 16
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic lclk_i,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_dly_en_o,
	input wire logic tx_dly_en_o,
	input wire logic [5:0] rx_tap_o
);
	// Link side after reset: the windows assume the default tuning period of 16.
	property p_rx_dly_dflt;
		@(posedge lclk_i) disable iff (rst_i) $fell(rst_i) |-> ##[2:20] rx_dly_en_o;
	endproperty
	a_rx_dly_dflt: assert property (p_rx_dly_dflt) else $error("receive delay off after reset");
	property p_tx_byp_dflt;
		@(posedge lclk_i) disable iff (rst_i) $fell(rst_i) |-> (!tx_dly_en_o) [*8];
	endproperty
	a_tx_byp_dflt: assert property (p_tx_byp_dflt) else $error("transmit delay on after reset");
	property p_tap_init;
		@(posedge lclk_i) disable iff (rst_i) $fell(rst_i) |-> ##[2:14] rx_tap_o == 6'h10;
	endproperty
	a_tap_init: assert property (p_tap_init) else $error("initial tap not the select value");
	property p_tap_tune;
		@(posedge lclk_i) disable iff (rst_i) $fell(rst_i) |-> ##[14:60] rx_tap_o == 6'h20;
	endproperty
	a_tap_tune: assert property (p_tap_tune) else $error("tuned tap not reached");
	// Register bus answers; a late answer would leave a DLL reset write unseen.
	property p_wr_ans;
		@(posedge mclk_i) disable iff (rst_i)
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write response late");
	property p_rd_ans;
		@(posedge mclk_i) disable iff (rst_i) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read data late");
	property p_b_once;
		@(posedge mclk_i) disable iff (rst_i) s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_once: assert property (p_b_once) else $error("write response repeated");
	property p_r_once;
		@(posedge mclk_i) disable iff (rst_i) s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_r_once: assert property (p_r_once) else $error("read data repeated");
endmodule

bind rgd_dll_skew rgd_dll_skew_asserts #(.TUNE_CYC(TUNE_CYC)) u_rgd_dll_skew_asserts (
	.mclk_i(mclk_i),
	.rst_i(rst_i),
	.lclk_i(lclk_i),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.rx_dly_en_o(rx_dly_en_o),
	.tx_dly_en_o(tx_dly_en_o),
	.rx_tap_o(rx_tap_o)
);
`default_nettype wire

//--- rgd_mac_model.sv
// Behavioural MAC side of the link: it sources the transmit clock that the tuners run on.
// Assumes the bench wants a free-running clock, unrelated in phase to the register clock.
`timescale 1ns/100ps
`default_nettype none
module rgd_mac_model #(
	parameter real HALF_NS = 24.0,
	parameter real SKEW_NS = 7.0
) (
	output logic lclk_o
);
	// The offset stands for the MAC's own clock delay and keeps edges off the bus clock.
	initial begin
		lclk_o = 1'h0;
		#(SKEW_NS);
		forever #(HALF_NS) lclk_o = ~lclk_o;
	end
endmodule
`default_nettype wire

//--- rgd_dll_skew_tb_top.sv
// Self-checking bench for the DLL skew block: register bus, modes, taps and DLL resets.
// Assumes the MAC model gives the link clock and the checker is bound to the design.
`timescale 1ns/100ps
`default_nettype none
`include "rgd_consts.svh"
module rgd_dll_skew_tb_top;
	localparam int TUNE = 16;
	localparam logic [5:0] NOM = 6'(`RGD_DLY_PS / `RGD_TAP_PS);
	logic mclk_i, rst_i, lclk_i, awv, awrdy, wv, wrdy, bv, brdy, arv, arrdy, rv, rrdy;
	logic [7:0] awa, ara;
	logic [31:0] wd, rd;
	logic [3:0] ws;
	logic [1:0] bresp, rresp;
	logic rx_en, tx_en, both_e;
	logic [5:0] rx_tap, tx_tap;
	int err_count, num_checks;

	// Register clock at 25 MHz.
	initial begin
		mclk_i = 1'h0;
		forever #20 mclk_i = ~mclk_i;
	end

	rgd_dll_skew #(.TUNE_CYC(TUNE)) u_rgd_dll_skew (.mclk_i(mclk_i), .rst_i(rst_i),
		.lclk_i(lclk_i), .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
		.s_axi_arready(arrdy), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
		.s_axi_rdata(rd), .s_axi_rresp(rresp), .rx_dly_en_o(rx_en), .tx_dly_en_o(tx_en),
		.rx_tap_o(rx_tap), .tx_tap_o(tx_tap), .both_edges_data_o(both_e));
	rgd_mac_model u_rgd_mac_model (.lclk_o(lclk_i));

	// Compare helpers; case inequality so an unknown never passes.
	task chk_w(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t word got %h expected %h", $time, g, e);
		end
	endtask
	task chk_b(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t bit got %b expected %b", $time, g, e);
		end
	endtask

	// Bus master: each channel is held until its own ready is seen at an edge.
	task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic ta, tw;
		ta = 1'h0;
		tw = 1'h0;
		n = 0;
		@(posedge mclk_i);
		awv <= 1'h1;
		awa <= a;
		wv <= 1'h1;
		wd <= d;
		brdy <= 1'h1;
		while (!(ta && tw) && n < 50) begin
			@(posedge mclk_i);
			n++;
			if (awv && awrdy) begin
				ta = 1'h1;
				awv <= 1'h0;
			end
			if (wv && wrdy) begin
				tw = 1'h1;
				wv <= 1'h0;
			end
		end
		do begin @(posedge mclk_i); n++; end while (bv !== 1'h1 && n < 50);
		r = bresp;
		brdy <= 1'h0;
		if (n >= 50) begin
			err_count++;
			$display("[ERR] %0t write got no answer", $time);
		end
	endtask
	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge mclk_i);
		arv <= 1'h1;
		ara <= a;
		rrdy <= 1'h1;
		do begin @(posedge mclk_i); n++; end while (arrdy !== 1'h1 && n < 50);
		arv <= 1'h0;
		do begin @(posedge mclk_i); n++; end while (rv !== 1'h1 && n < 50);
		d = rd;
		r = rresp;
		rrdy <= 1'h0;
		if (n >= 50) begin
			err_count++;
			$display("[ERR] %0t read got no answer", $time);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk_w({30'h0, r}, {30'h0, `RGD_RESP_OKAY});
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk_w({30'h0, r}, {30'h0, `RGD_RESP_OKAY});
		chk_w(d & m, e);
	endtask
	// Longer than two crossing rounds plus one tuning period, so outputs have landed.
	task settle();
		repeat (40) @(posedge lclk_i);
	endtask
	task do_reset();
		rst_i <= 1'h1;
		repeat (8) @(posedge mclk_i);
		rst_i <= 1'h0;
		repeat (70) @(posedge lclk_i);
	endtask

	// Scenarios.
	task t_defaults();
		rd_chk(`RGD_OFS_MODE, 32'hFFFFFFFF, `RGD_MODE_RST);
		rd_chk(`RGD_OFS_RXCTL, 32'hFFFFFFFF, `RGD_RXCTL_RST);
		rd_chk(`RGD_OFS_TXCTL, 32'hFFFFFFFF, `RGD_TXCTL_RST);
		rd_chk(`RGD_OFS_DLLRST, 32'hFFFFFFFF, `RGD_DLLRST_RST);
		chk_b(rx_en, 1'h1);
		chk_b(tx_en, 1'h0);
		chk_b(both_e, 1'h1);
		chk_w({26'h0, rx_tap}, {26'h0, NOM});
	endtask
	task t_speed();
		logic [1:0] spd [3];
		spd = '{`RGD_SPD_10, `RGD_SPD_100, `RGD_SPD_1000};
		for (int i = 0; i < 3; i++) begin
			wr(`RGD_OFS_MODE, {29'h0, spd[i], 1'h0});
			settle();
			chk_b(both_e, spd[i] == `RGD_SPD_1000);
		end
	endtask
	task t_dest();
		wr(`RGD_OFS_MODE, {29'h0, `RGD_SPD_1000, 1'h1});
		settle();
		chk_b(rx_en, 1'h0);
		chk_b(tx_en, 1'h1);
		rd_chk(`RGD_OFS_STAT, 32'h000C0000, 32'h00080000);
		wr(`RGD_OFS_MODE, {29'h0, `RGD_SPD_1000, 1'h0});
		settle();
		chk_b(rx_en, 1'h1);
		chk_b(tx_en, 1'h0);
	endtask
	task t_bypass();
		wr(`RGD_OFS_RXCTL, 32'h00001001);
		wr(`RGD_OFS_TXCTL, 32'h00001000);
		settle();
		chk_b(rx_en, 1'h0);
		chk_b(tx_en, 1'h1);
		wr(`RGD_OFS_RXCTL, `RGD_RXCTL_RST);
		wr(`RGD_OFS_TXCTL, `RGD_TXCTL_RST);
		settle();
		chk_b(rx_en, 1'h1);
		chk_b(tx_en, 1'h0);
	endtask
	task t_adjust();
		wr(`RGD_OFS_RXCTL, 32'h00001040);
		settle();
		chk_w({26'h0, rx_tap}, {26'h0, NOM - 6'h04});
		wr(`RGD_OFS_RXCTL, 32'h00001080);
		settle();
		chk_w({26'h0, rx_tap}, {26'h0, NOM - 6'h08});
		wr(`RGD_OFS_RXCTL, `RGD_RXCTL_RST);
	endtask
	task t_dll_reset();
		logic seen;
		seen = 1'h0;
		wr(`RGD_OFS_TXCTL, 32'h00000A00);
		wr(`RGD_OFS_DLLRST, 32'h00000002);
		settle();
		chk_w({26'h0, tx_tap}, 32'h00000000);
		rd_chk(`RGD_OFS_DLLRST, 32'hFFFFFFFF, 32'h00000002);
		rd_chk(`RGD_OFS_STAT, 32'h00023F00, 32'h00000000);
		wr(`RGD_OFS_DLLRST, 32'h00000000);
		repeat (40) begin
			@(posedge lclk_i);
			if (tx_tap === 6'h0A) seen = 1'h1;
		end
		chk_b(seen, 1'h1);
		settle();
		chk_w({26'h0, tx_tap}, {26'h0, NOM});
		rd_chk(`RGD_OFS_STAT, 32'h00023F00, {14'h0, 1'h1, 3'h0, NOM, 8'h00});
	endtask
	task t_fixed();
		wr(`RGD_OFS_RXCTL, 32'h00001030);
		wr(`RGD_OFS_TXCTL, 32'h00000532);
		wr(`RGD_OFS_DLLRST, 32'h00000002);
		settle();
		wr(`RGD_OFS_DLLRST, 32'h00000000);
		settle();
		settle();
		chk_w({26'h0, tx_tap}, 32'h00000005);
		chk_w({26'h0, rx_tap}, {26'h0, NOM - 6'h03});
		wr(`RGD_OFS_RXCTL, `RGD_RXCTL_RST);
	endtask
	task t_unmapped();
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(8'h14, d, r);
		chk_w({30'h0, r}, {30'h0, `RGD_RESP_SLVERR});
		chk_w(d, 32'h00000000);
		axi_wr(8'h14, 32'hFFFFFFFF, r);
		chk_w({30'h0, r}, {30'h0, `RGD_RESP_SLVERR});
	endtask

	task finish_test();
		$display("mismatches %0d comparisons %0d", err_count, num_checks);
		if (err_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Main sequence; the second reset shows the defaults return after heavy use.
	initial begin
		err_count = 0;
		num_checks = 0;
		rst_i = 1'h1;
		{awv, wv, brdy, arv, rrdy} = 5'h00;
		awa = 8'h00;
		ara = 8'h00;
		wd = 32'h00000000;
		ws = 4'hF;
		do_reset();
		t_defaults();
		t_speed();
		t_dest();
		t_bypass();
		t_adjust();
		t_dll_reset();
		t_fixed();
		t_unmapped();
		do_reset();
		t_defaults();
		finish_test();
	end

	// Watchdog well beyond the expected run of about 40 microseconds.
	initial begin
		#300000;
		err_count++;
		$display("[ERR] %0t watchdog expired", $time);
		finish_test();
	end
endmodule
`default_nettype wire
